// ===== shared/dcr_pkg.sv
/*
 * Constants for the line interface control register bank (registers 1-5):
 * register indices, field positions, reset values, ring hold timing.
 * Assumes a single 40 MHz core clock shared by every user of the package.
 */
// Functional notes
// - Writing one to control_one bit 7 restores every register to reset.
// - The soft reset bit clears itself; reads of it always return zero.
// - control_one bit 1 drives isolation digital loopback on or off.
// - Word mode zero: 15-bit words, word LSB requests a secondary frame.
// - Word mode one: 16-bit words, secondary frame requests are not honoured.
// - Word mode bit is sticky against writes; only reset clears it.
// - control_two bit 3 drives external analog loopback on or off.
// - control_two bit 1 connects the hybrid into the transmit path.
// - control_two bit 0 enables the receive path.
// - Ring indicator sets on ring, clears 4.5 s after positive ring or on off-hook with no ring present.
// - Negative ring flag follows the negative ring signal on the line.
// - Off-hook bit one takes the line side off-hook, zero leaves it on-hook.
package dcr_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned WORD_W = 16;

   localparam logic [4:0] ADDR_CONTROL_ONE = 5'h01;
   localparam logic [4:0] ADDR_CONTROL_TWO = 5'h02;
   localparam logic [4:0] ADDR_RESERVED_THREE = 5'h03;
   localparam logic [4:0] ADDR_RESERVED_FOUR = 5'h04;
   localparam logic [4:0] ADDR_LINE_CONTROL_STATUS = 5'h05;

   // control_one fields
   localparam int unsigned BIT_SOFT_RESET = 7;
   localparam int unsigned BIT_ISO_LOOPBACK = 1;
   localparam int unsigned BIT_WORD_MODE = 0;
   // control_two fields
   localparam int unsigned BIT_ANALOG_LOOPBACK = 3;
   localparam int unsigned BIT_HYBRID = 1;
   localparam int unsigned BIT_RX_ENABLE = 0;
   // line_control_status fields
   localparam int unsigned BIT_RING_NEG = 6;
   localparam int unsigned BIT_RING_POS = 5;
   localparam int unsigned BIT_ONHOOK_MON = 3;
   localparam int unsigned BIT_RING_IND = 2;
   localparam int unsigned BIT_OFF_HOOK = 0;

   localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
   localparam logic [7:0] RST_CONTROL_TWO = 8'h03;
   localparam logic [7:0] RST_LINE_CONTROL_STATUS = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   localparam int unsigned CLK_HZ = 40_000_000;
   // Ring indicator hold window is 4.5 to 9 s; the short end is used
   localparam int unsigned RING_HOLD_MS = 4500;
   localparam int unsigned RING_HOLD_CYC = RING_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned RING_CNT_W = 28;
endpackage : dcr_pkg

// ===== design/dcr_sync2.sv
/*
 * Two-stage synchroniser for level signals arriving from the line side.
 * Assumes the inputs are quasi-static levels; no pulse stretching is done.
 */
`timescale 1ns/1ps
module dcr_sync2 #(
   parameter int unsigned WIDTH = 2
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule // dcr_sync2

// ===== design/dcr_ring_timer.sv
/*
 * Ring indicator with hold timer. Sets while a ring is present, clears
 * once HOLD_CYC cycles with no ring at all pass after the last positive ring, or on going off-hook with no ring present.
 * Assumes ring inputs are already synchronised to core_clk_i.
 */
`timescale 1ns/1ps
module dcr_ring_timer
   import dcr_pkg::*;
#(
   parameter int unsigned HOLD_CYC = RING_HOLD_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic soft_clr_i,
   input wire logic ring_pos_i,
   input wire logic ring_neg_i,
   input wire logic offhook_rise_i,
   output logic ring_ind_o
);
   logic [RING_CNT_W-1:0] hold_cnt;
   logic [RING_CNT_W-1:0] next_hold_cnt;
   logic next_ring_ind;
   logic [RING_CNT_W-1:0] hold_last;

   assign hold_last = RING_CNT_W'(HOLD_CYC - 1);

   always_comb
   begin
      next_ring_ind = ring_ind_o;
      next_hold_cnt = hold_cnt;
      if (soft_clr_i)
      begin
         next_ring_ind = 1'b0;
         next_hold_cnt = '0;
      end
      else if (ring_pos_i || ring_neg_i)
      begin
         // A ring in the off-hook cycle still wins over the clear
         next_ring_ind = 1'b1;
         if (ring_pos_i)
            next_hold_cnt = '0;
      end
      else if (offhook_rise_i)
      begin
         next_ring_ind = 1'b0;
         next_hold_cnt = '0;
      end
      else if (ring_ind_o)
      begin
         if (hold_cnt == hold_last)
         begin
            next_ring_ind = 1'b0;
            next_hold_cnt = '0;
         end
         else
            next_hold_cnt = hold_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ring_ind_o <= 1'b0;
         hold_cnt <= '0;
      end
      else
      begin
         ring_ind_o <= next_ring_ind;
         hold_cnt <= next_hold_cnt;
      end
   end
endmodule // dcr_ring_timer

// ===== design/dcr_regs.sv
/*
 * Control and status register bank, registers 1 to 5, of the system-side
 * line interface module. Register access arrives as decoded single-cycle
 * read and write strobes from the serial port framer; line-side ring
 * status arrives asynchronously and is synchronised here. Serial data
 * words pass through with word-mode formatting applied.
 * Assumes the framer and serial data logic run on core_clk_i.
 */
`timescale 1ns/1ps
module dcr_regs
   import dcr_pkg::*;
#(
   parameter int unsigned HOLD_CYC = RING_HOLD_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic ring_pos_line_i,
   input wire logic ring_neg_line_i,
   input wire logic [WORD_W-1:0] word_i,
   input wire logic word_valid_i,
   output logic [WORD_W-1:0] word_o,
   output logic word_valid_o,
   output logic secondary_frame_req_o,
   output logic isolation_digital_loopback_o,
   output logic serial_word_mode_o,
   output logic analog_loopback_enable_o,
   output logic hybrid_connect_o,
   output logic receive_path_enable_o,
   output logic onhook_line_monitor_o,
   output logic off_hook_o
);
   // Stored fields
   logic iso_lb;
   logic word_mode;
   logic analog_lb;
   logic hybrid;
   logic rx_en;
   logic onhook_mon;
   logic off_hook;
   logic next_iso_lb;
   logic next_word_mode;
   logic next_analog_lb;
   logic next_hybrid;
   logic next_rx_en;
   logic next_onhook_mon;
   logic next_off_hook;
   logic soft_reset;

   logic [DATA_W-1:0] next_rdata;
   logic next_rvalid;
   logic [WORD_W-1:0] next_word;
   logic next_word_valid;
   logic next_sec_req;

   logic [1:0] ring_sync;
   logic ring_pos;
   logic ring_neg;
   logic ring_ind;
   logic offhook_rise;

   logic wr_one;
   logic wr_two;
   logic wr_five;

   dcr_sync2 #(
      .WIDTH(2)
   ) u_ring_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .async_i({ring_neg_line_i, ring_pos_line_i}),
      .sync_o(ring_sync)
   );

   assign ring_pos = ring_sync[0];
   assign ring_neg = ring_sync[1];

   assign wr_one = reg_wr_i && (reg_addr_i == ADDR_CONTROL_ONE);
   assign wr_two = reg_wr_i && (reg_addr_i == ADDR_CONTROL_TWO);
   assign wr_five = reg_wr_i && (reg_addr_i == ADDR_LINE_CONTROL_STATUS);
   // Soft reset is never stored, so it reads back as zero
   assign soft_reset = wr_one && reg_wdata_i[BIT_SOFT_RESET];
   assign offhook_rise = next_off_hook && !off_hook;

   dcr_ring_timer #(
      .HOLD_CYC(HOLD_CYC)
   ) u_ring_timer (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .soft_clr_i(soft_reset),
      .ring_pos_i(ring_pos),
      .ring_neg_i(ring_neg),
      .offhook_rise_i(offhook_rise),
      .ring_ind_o(ring_ind)
   );

   // Control field updates
   always_comb
   begin
      next_iso_lb = iso_lb;
      next_word_mode = word_mode;
      next_analog_lb = analog_lb;
      next_hybrid = hybrid;
      next_rx_en = rx_en;
      next_onhook_mon = onhook_mon;
      next_off_hook = off_hook;
      if (soft_reset)
      begin
         // The rest of the resetting write is discarded
         next_iso_lb = RST_CONTROL_ONE[BIT_ISO_LOOPBACK];
         next_word_mode = RST_CONTROL_ONE[BIT_WORD_MODE];
         next_analog_lb = RST_CONTROL_TWO[BIT_ANALOG_LOOPBACK];
         next_hybrid = RST_CONTROL_TWO[BIT_HYBRID];
         next_rx_en = RST_CONTROL_TWO[BIT_RX_ENABLE];
         next_onhook_mon = RST_LINE_CONTROL_STATUS[BIT_ONHOOK_MON];
         next_off_hook = RST_LINE_CONTROL_STATUS[BIT_OFF_HOOK];
      end
      else
      begin
         if (wr_one)
         begin
            next_iso_lb = reg_wdata_i[BIT_ISO_LOOPBACK];
            // Sticky: a write of zero cannot clear it
            next_word_mode = word_mode | reg_wdata_i[BIT_WORD_MODE];
         end
         if (wr_two)
         begin
            next_analog_lb = reg_wdata_i[BIT_ANALOG_LOOPBACK];
            next_hybrid = reg_wdata_i[BIT_HYBRID];
            next_rx_en = reg_wdata_i[BIT_RX_ENABLE];
         end
         if (wr_five)
         begin
            // Ring status bits ignore write data, though going off-hook with no ring present clears the ring indicator
            next_onhook_mon = reg_wdata_i[BIT_ONHOOK_MON];
            next_off_hook = reg_wdata_i[BIT_OFF_HOOK];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         iso_lb <= RST_CONTROL_ONE[BIT_ISO_LOOPBACK];
         word_mode <= RST_CONTROL_ONE[BIT_WORD_MODE];
         analog_lb <= RST_CONTROL_TWO[BIT_ANALOG_LOOPBACK];
         hybrid <= RST_CONTROL_TWO[BIT_HYBRID];
         rx_en <= RST_CONTROL_TWO[BIT_RX_ENABLE];
         onhook_mon <= RST_LINE_CONTROL_STATUS[BIT_ONHOOK_MON];
         off_hook <= RST_LINE_CONTROL_STATUS[BIT_OFF_HOOK];
      end
      else
      begin
         iso_lb <= next_iso_lb;
         word_mode <= next_word_mode;
         analog_lb <= next_analog_lb;
         hybrid <= next_hybrid;
         rx_en <= next_rx_en;
         onhook_mon <= next_onhook_mon;
         off_hook <= next_off_hook;
      end
   end

   assign isolation_digital_loopback_o = iso_lb;
   assign serial_word_mode_o = word_mode;
   assign analog_loopback_enable_o = analog_lb;
   assign hybrid_connect_o = hybrid;
   assign receive_path_enable_o = rx_en;
   assign onhook_line_monitor_o = onhook_mon;
   assign off_hook_o = off_hook;

   // Read path; unmapped and reserved locations answer zero
   always_comb
   begin
      next_rdata = READ_ZERO;
      next_rvalid = reg_rd_i;
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            ADDR_CONTROL_ONE:
            begin
               next_rdata[BIT_ISO_LOOPBACK] = iso_lb;
               next_rdata[BIT_WORD_MODE] = word_mode;
            end
            ADDR_CONTROL_TWO:
            begin
               next_rdata[BIT_ANALOG_LOOPBACK] = analog_lb;
               next_rdata[BIT_HYBRID] = hybrid;
               next_rdata[BIT_RX_ENABLE] = rx_en;
            end
            ADDR_LINE_CONTROL_STATUS:
            begin
               next_rdata[BIT_RING_NEG] = ring_neg;
               next_rdata[BIT_RING_POS] = ring_pos;
               next_rdata[BIT_ONHOOK_MON] = onhook_mon;
               next_rdata[BIT_RING_IND] = ring_ind;
               next_rdata[BIT_OFF_HOOK] = off_hook;
            end
            default:
               next_rdata = READ_ZERO;
         endcase
      end
   end

   // Serial word formatting
   always_comb
   begin
      next_word = word_o;
      next_word_valid = word_valid_i;
      next_sec_req = 1'b0;
      if (word_valid_i)
      begin
         if (word_mode)
            next_word = word_i;
         else
         begin
            // LSB is the secondary frame flag, not data
            next_word = {word_i[WORD_W-1:1], 1'b0};
            next_sec_req = word_i[0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o <= READ_ZERO;
         reg_rvalid_o <= 1'b0;
         word_o <= '0;
         word_valid_o <= 1'b0;
         secondary_frame_req_o <= 1'b0;
      end
      else
      begin
         reg_rdata_o <= next_rdata;
         reg_rvalid_o <= next_rvalid;
         word_o <= next_word;
         word_valid_o <= next_word_valid;
         secondary_frame_req_o <= next_sec_req;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_soft_reset_clears;
      soft_reset |=> !iso_lb && !word_mode && !analog_lb && hybrid && rx_en
         && !onhook_mon && !off_hook && !ring_ind;
   endproperty
   a_soft_reset_clears: assert property (p_soft_reset_clears)
      else $error("soft reset did not restore reset values");

   property p_soft_reset_reads_zero;
      reg_rd_i && reg_addr_i == ADDR_CONTROL_ONE
         |=> reg_rvalid_o && !reg_rdata_o[BIT_SOFT_RESET];
   endproperty
   a_soft_reset_reads_zero: assert property (p_soft_reset_reads_zero)
      else $error("soft reset bit read back as one");

   property p_iso_loopback;
      wr_one && !soft_reset
         |=> isolation_digital_loopback_o == $past(reg_wdata_i[1]);
   endproperty
   a_iso_loopback: assert property (p_iso_loopback)
      else $error("isolation loopback does not follow write");

   property p_word15;
      word_valid_i && !word_mode
         |=> word_valid_o && secondary_frame_req_o == $past(word_i[0])
            && !word_o[0]
            && word_o[WORD_W-1:1] == $past(word_i[WORD_W-1:1]);
   endproperty
   a_word15: assert property (p_word15)
      else $error("15-bit word handling wrong");

   property p_word16;
      word_valid_i && word_mode
         |=> !secondary_frame_req_o && word_o == $past(word_i);
   endproperty
   a_word16: assert property (p_word16)
      else $error("16-bit word handling wrong");

   property p_word_mode_sticky;
      word_mode && !soft_reset |=> word_mode [*2] or (word_mode ##1 1'b1);
   endproperty
   a_word_mode_sticky: assert property (p_word_mode_sticky)
      else $error("word mode cleared by a write");

   property p_ctrl_two;
      wr_two && !soft_reset |=> {analog_lb, hybrid, rx_en}
         == {$past(reg_wdata_i[3]), $past(reg_wdata_i[1]),
            $past(reg_wdata_i[0])};
   endproperty
   a_ctrl_two: assert property (p_ctrl_two)
      else $error("control_two fields do not follow write");

   // Each mapped register has its own reserved mask; the rest read zero
   property p_reserved_zero;
      reg_rd_i |=> (reg_rdata_o
         & ($past(reg_addr_i) == ADDR_CONTROL_ONE ? 8'hfc
            : $past(reg_addr_i) == ADDR_CONTROL_TWO ? 8'hf4
            : $past(reg_addr_i) == ADDR_LINE_CONTROL_STATUS ? 8'h92
            : 8'hff)) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");

   property p_ring_neg_flag;
      reg_rd_i && reg_addr_i == ADDR_LINE_CONTROL_STATUS
         |=> reg_rdata_o[BIT_RING_NEG] == $past(ring_neg);
   endproperty
   a_ring_neg_flag: assert property (p_ring_neg_flag)
      else $error("negative ring flag wrong");

   property p_offhook_clears_ring;
      offhook_rise && !ring_pos && !ring_neg |=> !ring_ind;
   endproperty
   a_offhook_clears_ring: assert property (p_offhook_clears_ring)
      else $error("off-hook did not clear ring indicator");

   property p_offhook_follows;
      wr_five && !soft_reset
         |=> off_hook_o == $past(reg_wdata_i[BIT_OFF_HOOK])
            && onhook_line_monitor_o == $past(reg_wdata_i[BIT_ONHOOK_MON])
            && (!ring_ind || $past(ring_ind || ring_pos || ring_neg));
   endproperty
   a_offhook_follows: assert property (p_offhook_follows)
      else $error("off-hook write handling wrong");

   c_soft_reset: cover property (soft_reset ##1 reg_rd_i);
   c_ring_then_offhook: cover property (ring_ind ##[1:20] offhook_rise);
   c_word16: cover property (word_mode && word_valid_i && word_i[0]);
   c_sec_req: cover property (secondary_frame_req_o);
endmodule // dcr_regs

// ===== dv/dcr_host_model.sv
/*
 * Host-side model of the serial port framer: issues single-cycle decoded
 * register write and read strobes to the register bank.
 * Assumes the bank answers a read with rvalid exactly one cycle later.
 */
`timescale 1ns/1ps
module dcr_host_model
   import dcr_pkg::*;
(
   input wire logic core_clk_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [ADDR_W-1:0] reg_addr_o,
   output logic [DATA_W-1:0] reg_wdata_o,
   input wire logic [DATA_W-1:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   initial
   begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = '0;
      reg_wdata_o = '0;
   end

   // Released lines show the inverse so a stale value cannot pass
   task automatic write_reg(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
      #1;
   endtask

   task automatic read_reg(input logic [ADDR_W-1:0] a,
                           output logic [DATA_W:0] q);
      @(posedge core_clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge core_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      q = {reg_rvalid_i, reg_rdata_i};
   endtask
endmodule // dcr_host_model

// ===== dv/dcr_regs_tb_top.sv
/*
 * Self-checking bench for the line interface register bank: reset values,
 * table of write/read rows, then word path, ring, soft reset and reset cases.
 * Assumes a shortened ring hold time of 20 cycles.
 */
`timescale 1ns/1ps
module dcr_regs_tb_top;
   import dcr_pkg::*;
   localparam int unsigned HOLD = 20;
   typedef struct packed {
      logic [4:0] a;
      logic [7:0] d;
      logic [7:0] rd;
      logic [6:0] ctl;
   } dcr_row_t;
   logic core_clk, rst_n, rd_v, wr_v, ring_pos, ring_neg, word_valid;
   logic word_valid_o, sec_req, iso, mode, al, hyb, rx, onhook_line_monitor, oh;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [WORD_W-1:0] word_in, word_out;
   logic [6:0] ctl;
   logic rd_valid;
   logic [8:0] q;
   int err_count = 0;
   int n_tests = 0;
   logic [7:0] rst_val [5] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
   dcr_row_t rows [11] = '{
      '{5'h02, 8'h08, 8'h08, 7'h10},
      '{5'h02, 8'hff, 8'h0b, 7'h1c},
      '{5'h05, 8'h08, 8'h08, 7'h1e},
      '{5'h05, 8'h00, 8'h00, 7'h1c},
      '{5'h05, 8'hf5, 8'h01, 7'h1d},
      '{5'h01, 8'h7e, 8'h02, 7'h5d},
      '{5'h03, 8'hff, 8'h00, 7'h5d},
      '{5'h04, 8'hff, 8'h00, 7'h5d},
      '{5'h00, 8'hff, 8'h00, 7'h5d},
      '{5'h06, 8'hff, 8'h00, 7'h5d},
      '{5'h1f, 8'hff, 8'h00, 7'h5d}};
   assign ctl = {iso, mode, al, hyb, rx, onhook_line_monitor, oh};

   dcr_host_model i_host (.core_clk_i(core_clk), .reg_wr_o(wr_v),
      .reg_rd_o(rd_v), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_rdata_i(rdata), .reg_rvalid_i(rd_valid));
   dcr_regs #(.HOLD_CYC(HOLD)) i_dut (.core_clk_i(core_clk),
      .rst_n_i(rst_n), .reg_wr_i(wr_v), .reg_rd_i(rd_v),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .reg_rvalid_o(rd_valid), .ring_pos_line_i(ring_pos),
      .ring_neg_line_i(ring_neg), .word_i(word_in),
      .word_valid_i(word_valid), .word_o(word_out),
      .word_valid_o(word_valid_o), .secondary_frame_req_o(sec_req),
      .isolation_digital_loopback_o(iso), .serial_word_mode_o(mode),
      .analog_loopback_enable_o(al), .hybrid_connect_o(hyb),
      .receive_path_enable_o(rx), .onhook_line_monitor_o(onhook_line_monitor),
      .off_hook_o(oh));

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time,
                  seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      i_host.read_reg(a, q);
      check({9'h0, q}, {10'h1, exp});
   endtask

   // Word checks also see the pulses drop after one cycle
   task automatic word_pair(input logic [15:0] w1, input logic [17:0] e1,
                            input logic [15:0] w2, input logic [17:0] e2);
      @(posedge core_clk);
      word_valid <= 1'b1;
      word_in <= w1;
      @(posedge core_clk);
      word_in <= w2;
      #1;
      check({word_valid_o, sec_req, word_out}, e1);
      @(posedge core_clk);
      word_valid <= 1'b0;
      word_in <= ~w2;
      #1;
      check({word_valid_o, sec_req, word_out}, e2);
      @(posedge core_clk);
      #1;
      check({word_valid_o, sec_req}, 18'h0);
   endtask

   task automatic ring_step(input logic p, input logic n, input int cyc,
                            input logic [7:0] exp);
      @(posedge core_clk);
      ring_pos <= p;
      ring_neg <= n;
      repeat (cyc) @(posedge core_clk);
      rd_chk(ADDR_LINE_CONTROL_STATUS, exp);
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      complete_run();
   end

   initial
   begin
      rst_n = 1'b0;
      ring_pos = 1'b0;
      ring_neg = 1'b0;
      word_valid = 1'b0;
      word_in = '0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      check(ctl, 7'h0c);
      for (int i = 0; i < 5; i++)
         rd_chk(5'(i + 1), rst_val[i]);
      foreach (rows[i])
      begin
         i_host.write_reg(rows[i].a, rows[i].d);
         check(ctl, rows[i].ctl);
         rd_chk(rows[i].a, rows[i].rd);
      end
      word_pair(16'h0003, 18'h30002, 16'hfffe, 18'h2fffe);
      // Word mode set on purpose although the host is advised against it
      i_host.write_reg(ADDR_CONTROL_ONE, 8'h03);
      i_host.write_reg(ADDR_CONTROL_ONE, 8'h02);
      check(ctl, 7'h7d);
      rd_chk(ADDR_CONTROL_ONE, 8'h03);
      word_pair(16'h0003, 18'h20003, 16'h0001, 18'h20001);
      i_host.write_reg(ADDR_LINE_CONTROL_STATUS, 8'h00);
      check(ctl, 7'h7c);
      ring_step(1'b0, 1'b1, 6, 8'h44);
      ring_step(1'b1, 1'b0, 6, 8'h24);
      ring_step(1'b0, 1'b0, 4, 8'h04);
      ring_step(1'b0, 1'b0, HOLD + 10, 8'h00);
      ring_step(1'b1, 1'b0, 6, 8'h24);
      ring_step(1'b0, 1'b0, 2, 8'h04);
      i_host.write_reg(ADDR_LINE_CONTROL_STATUS, 8'h01);
      rd_chk(ADDR_LINE_CONTROL_STATUS, 8'h01);
      i_host.write_reg(ADDR_CONTROL_ONE, 8'h83);
      check(ctl, 7'h0c);
      rd_chk(ADDR_CONTROL_ONE, 8'h00);
      rd_chk(ADDR_CONTROL_TWO, 8'h03);
      rd_chk(ADDR_LINE_CONTROL_STATUS, 8'h00);
      i_host.write_reg(ADDR_CONTROL_TWO, 8'h08);
      check(ctl, 7'h10);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check(ctl, 7'h0c);
      @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk(ADDR_CONTROL_TWO, 8'h03);
      complete_run();
   end
endmodule // dcr_regs_tb_top
